// ===== rtl/pgcd_pkg.sv
package pgcd_pkg;

    // ==========================================================
    // register byte addresses on the apb bus
    localparam logic [11:0] GEN_CTRL_ADDR = 12'h000;
    localparam logic [11:0] PRIM_DT_ADDR = 12'h004;
    localparam logic [11:0] ALT_DT_ADDR = 12'h008;
    localparam logic [11:0] FLT_CTRL_ADDR = 12'h00c;
    localparam logic [11:0] IRQ_STAT_ADDR = 12'h010;
    localparam logic [11:0] IRQ_MASK_ADDR = 12'h014;
    localparam logic [11:0] GLOBAL_ADDR = 12'h018;

    // ==========================================================
    // generator control field positions
    localparam int FLT_PEND_BIT = 15;
    localparam int CL_PEND_BIT = 14;
    localparam int TRG_PEND_BIT = 13;
    localparam int FLT_IEN_BIT = 12;
    localparam int CL_IEN_BIT = 11;
    localparam int TRG_IEN_BIT = 10;
    localparam int ITB_BIT = 9;
    localparam int MDCS_BIT = 8;
    localparam int DTC_HI_BIT = 7;
    localparam int DTC_LO_BIT = 6;
    localparam int DTCP_BIT = 5;
    localparam int MTBS_BIT = 3;
    localparam int CAM_BIT = 2;
    localparam int XPRES_BIT = 1;
    localparam int IUE_BIT = 0;
    // writable bits of the control word (status and bit 4 excluded)
    localparam logic [15:0] GEN_CTRL_WMASK = 16'h1fef;
    localparam logic [15:0] GEN_CTRL_RESET = 16'h0000;

    // ==========================================================
    // dead-time fields and fault/limit control
    localparam int DT_WIDTH = 14;
    localparam logic [13:0] DT_RESET = 14'h0000;
    localparam int CURRENT_LIMIT_MODE_SELECT_BIT = 0;
    localparam int GLB_EN_BIT = 0;

    // ==========================================================
    // sticky status bit positions
    localparam int ST_FLT_BIT = 0;
    localparam int ST_CL_BIT = 1;
    localparam int ST_TRG_BIT = 2;

endpackage : pgcd_pkg

// ===== rtl/pgcd_flag.sv
`timescale 1ns/10ps
// hardware-set pending flag, set beats clear
module pgcd_flag (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic setPulse,
    input wire logic clrReq,
    output logic flagOut
);
    logic flag_ff;
    logic nxt_flag;

    // ==========================================================
    // next value
    always_comb begin
        nxt_flag = flag_ff;
        if (clrReq) begin
            nxt_flag = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (setPulse) begin
            nxt_flag = 1'b1;
        end
    end

    // register stage
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flagOut = flag_ff;
endmodule : pgcd_flag

// ===== rtl/pgcd_top.sv
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
// Functional notes
// - centre alignment honoured only with independent period
// - period reset needs independent period, limit-mode zero
// - primary dead time is unsigned 14 bits
// - alternate dead time 14 bits, opposite edge
// - dead-time top two bits read zero
module pgcd_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic faultEvent,
    input wire logic currentLimitEvent,
    input wire logic triggerEvent,
    output logic independentPeriodSelect,
    output logic centerAlignedActive,
    output logic extPeriodResetActive,
    output logic masterDutySelect,
    output logic masterPeriodSelect,
    output logic [1:0] deadTimeCtrl,
    output logic deadTimePolarity,
    output logic immediateUpdate,
    output logic [13:0] risingDeadTime,
    output logic [13:0] fallingDeadTime,
    output logic moduleEnable,
    output logic irq
);
    // ==========================================================
    // state
    logic [15:0] ctrl_ff, nxt_ctrl; // control word, pending bits unused
    logic [13:0] primDt_ff, nxt_primDt; // primary dead time
    logic [13:0] altDt_ff, nxt_altDt; // alternate dead time
    logic clMode_ff, nxt_clMode; // current_limit_mode_select
    logic glbEn_ff, nxt_glbEn; // global module enable
    logic [2:0] sticky_ff, nxt_sticky; // interrupt status, read clears
    logic [2:0] mask_ff, nxt_mask; // interrupt mask
    logic [31:0] rdata_ff, nxt_rdata;
    logic ready_ff, nxt_ready;
    logic err_ff, nxt_err;
    logic [13:0] rise_ff, fall_ff;
    logic [8:0] cfg_ff, nxt_cfg; // decoded config outputs
    logic irq_ff, nxt_irq;
    logic [2:0] pend; // pending flags
    logic [2:0] evt; // event pulses
    logic [2:0] ienClr; // enable cleared this cycle
    logic wrCtrl;
    logic access;

    assign access = psel && penable && !ready_ff;
    assign wrCtrl = access && pwrite && (paddr == pgcd_pkg::GEN_CTRL_ADDR);
    assign evt = {triggerEvent, currentLimitEvent, faultEvent};

    // ==========================================================
    // pending flags: cleared by a control write with the enable bit low
    always_comb begin
        ienClr[0] = wrCtrl && !pwdata[pgcd_pkg::FLT_IEN_BIT];
        ienClr[1] = wrCtrl && !pwdata[pgcd_pkg::CL_IEN_BIT];
        ienClr[2] = wrCtrl && !pwdata[pgcd_pkg::TRG_IEN_BIT];
    end

    pgcd_flag uFlagFlt (.core_clk(core_clk), .sys_rst(sys_rst), .setPulse(evt[0]),
        .clrReq(ienClr[0]), .flagOut(pend[0]));
    pgcd_flag uFlagCl (.core_clk(core_clk), .sys_rst(sys_rst), .setPulse(evt[1]),
        .clrReq(ienClr[1]), .flagOut(pend[1]));
    pgcd_flag uFlagTrg (.core_clk(core_clk), .sys_rst(sys_rst), .setPulse(evt[2]),
        .clrReq(ienClr[2]), .flagOut(pend[2]));

    // ==========================================================
    // register file next values and apb answer
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_primDt = primDt_ff;
        nxt_altDt = altDt_ff;
        nxt_clMode = clMode_ff;
        nxt_glbEn = glbEn_ff;
        nxt_mask = mask_ff;
        nxt_rdata = rdata_ff;
        nxt_ready = 1'b0;
        nxt_err = 1'b0;
        // sticky status collects every event
        nxt_sticky = sticky_ff | evt;
        if (access) begin
            // one wait state: answer on the next edge
            nxt_ready = 1'b1;
            nxt_rdata = 32'h0000_0000;
            if (pwrite) begin
                unique case (paddr)
                    pgcd_pkg::GEN_CTRL_ADDR: begin
                        nxt_ctrl = pwdata[15:0] & pgcd_pkg::GEN_CTRL_WMASK;
                    end
                    pgcd_pkg::PRIM_DT_ADDR: begin
                        nxt_primDt = pwdata[13:0];
                    end
                    pgcd_pkg::ALT_DT_ADDR: begin
                        nxt_altDt = pwdata[13:0];
                    end
                    pgcd_pkg::FLT_CTRL_ADDR: begin
                        nxt_clMode = pwdata[pgcd_pkg::CURRENT_LIMIT_MODE_SELECT_BIT];
                    end
                    pgcd_pkg::IRQ_MASK_ADDR: begin
                        nxt_mask = pwdata[2:0];
                    end
                    pgcd_pkg::GLOBAL_ADDR: begin
                        nxt_glbEn = pwdata[pgcd_pkg::GLB_EN_BIT];
                    end
                    // status is read-only; writes ignored
                    pgcd_pkg::IRQ_STAT_ADDR: begin
                    end
                    default: begin
                        nxt_err = 1'b1;
                    end
                endcase
            end else begin
                unique case (paddr)
                    pgcd_pkg::GEN_CTRL_ADDR: begin
                        nxt_rdata = {16'h0000, pend[0], pend[1], pend[2], ctrl_ff[12:0]};
                    end
                    pgcd_pkg::PRIM_DT_ADDR: begin
                        nxt_rdata = {18'h00000, primDt_ff};
                    end
                    pgcd_pkg::ALT_DT_ADDR: begin
                        nxt_rdata = {18'h00000, altDt_ff};
                    end
                    pgcd_pkg::FLT_CTRL_ADDR: begin
                        nxt_rdata = {31'h00000000, clMode_ff};
                    end
                    pgcd_pkg::IRQ_STAT_ADDR: begin
                        nxt_rdata = {29'h00000000, sticky_ff};
                        // read clears; a same-cycle event stays set
                        nxt_sticky = evt;
                    end
                    pgcd_pkg::IRQ_MASK_ADDR: begin
                        nxt_rdata = {29'h00000000, mask_ff};
                    end
                    pgcd_pkg::GLOBAL_ADDR: begin
                        nxt_rdata = {31'h00000000, glbEn_ff};
                    end
                    default: begin
                        nxt_err = 1'b1;
                    end
                endcase
            end
        end
        nxt_irq = |(nxt_sticky & nxt_mask);
    end

    // ==========================================================
    // derived mode outputs
    always_comb begin
        nxt_cfg[0] = nxt_ctrl[pgcd_pkg::ITB_BIT];
        nxt_cfg[1] = nxt_ctrl[pgcd_pkg::CAM_BIT] && nxt_ctrl[pgcd_pkg::ITB_BIT];
        nxt_cfg[2] = nxt_ctrl[pgcd_pkg::XPRES_BIT] && nxt_ctrl[pgcd_pkg::ITB_BIT] && !nxt_clMode;
        nxt_cfg[3] = nxt_ctrl[pgcd_pkg::MDCS_BIT];
        nxt_cfg[4] = nxt_ctrl[pgcd_pkg::MTBS_BIT];
        nxt_cfg[6:5] = nxt_ctrl[pgcd_pkg::DTC_HI_BIT:pgcd_pkg::DTC_LO_BIT];
        nxt_cfg[7] = nxt_ctrl[pgcd_pkg::DTCP_BIT];
        nxt_cfg[8] = nxt_ctrl[pgcd_pkg::IUE_BIT];
    end

    // ==========================================================
    // registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_ff <= pgcd_pkg::GEN_CTRL_RESET;
            primDt_ff <= pgcd_pkg::DT_RESET;
            altDt_ff <= pgcd_pkg::DT_RESET;
            clMode_ff <= 1'b0;
            glbEn_ff <= 1'b0;
            sticky_ff <= 3'h0;
            mask_ff <= 3'h0;
            rdata_ff <= 32'h0000_0000;
            ready_ff <= 1'b0;
            err_ff <= 1'b0;
            rise_ff <= pgcd_pkg::DT_RESET;
            fall_ff <= pgcd_pkg::DT_RESET;
            cfg_ff <= 9'h000;
            irq_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            primDt_ff <= nxt_primDt;
            altDt_ff <= nxt_altDt;
            clMode_ff <= nxt_clMode;
            glbEn_ff <= nxt_glbEn;
            sticky_ff <= nxt_sticky;
            mask_ff <= nxt_mask;
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            err_ff <= nxt_err;
            rise_ff <= nxt_primDt;
            fall_ff <= nxt_altDt;
            cfg_ff <= nxt_cfg;
            irq_ff <= nxt_irq;
        end
    end

    // ==========================================================
    // outputs straight from flip-flops
    assign prdata = rdata_ff;
    assign pready = ready_ff;
    assign pslverr = err_ff;
    assign independentPeriodSelect = cfg_ff[0];
    assign centerAlignedActive = cfg_ff[1];
    assign extPeriodResetActive = cfg_ff[2];
    assign masterDutySelect = cfg_ff[3];
    assign masterPeriodSelect = cfg_ff[4];
    assign deadTimeCtrl = cfg_ff[6:5];
    assign deadTimePolarity = cfg_ff[7];
    assign immediateUpdate = cfg_ff[8];
    assign risingDeadTime = rise_ff;
    assign fallingDeadTime = fall_ff;
    assign moduleEnable = glbEn_ff;
    assign irq = irq_ff;
endmodule : pgcd_top

// ===== verif/pgcd_asserts.sv
`timescale 1ns/10ps
// ==========================================================
// port checker for the generator control block
module pgcd_asserts (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic independentPeriodSelect,
    input wire logic centerAlignedActive,
    input wire logic extPeriodResetActive,
    input wire logic [13:0] risingDeadTime,
    input wire logic [13:0] fallingDeadTime
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // first access cycle of an apb request
    sequence s_take;
        psel && penable && !pready;
    endsequence
    // one-cycle answer after the take edge
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_cam;
        centerAlignedActive |-> independentPeriodSelect;
    endproperty
    property p_xpres;
        extPeriodResetActive |-> independentPeriodSelect;
    endproperty
    property p_primWr;
        s_take and (pwrite && paddr == pgcd_pkg::PRIM_DT_ADDR) |=> risingDeadTime == $past(pwdata[13:0]);
    endproperty
    property p_primHold;
        !$stable(risingDeadTime) |-> $past(psel && penable && pwrite && !pready && paddr == pgcd_pkg::PRIM_DT_ADDR);
    endproperty
    property p_altWr;
        s_take and (pwrite && paddr == pgcd_pkg::ALT_DT_ADDR) |=> fallingDeadTime == $past(pwdata[13:0]);
    endproperty
    property p_rdZero;
        pready && !pwrite && (paddr == pgcd_pkg::PRIM_DT_ADDR || paddr == pgcd_pkg::ALT_DT_ADDR) |-> prdata[31:14] == 18'h0;
    endproperty
    property p_ready;
        s_take |=> s_answer;
    endproperty
    property p_err;
        pready && paddr > pgcd_pkg::GLOBAL_ADDR |-> pslverr && prdata == 32'h0;
    endproperty
    a_cam: assert property (p_cam) else $error("centre alignment without independent period");
    a_xpres: assert property (p_xpres) else $error("period reset without independent period");
    a_primWr: assert property (p_primWr) else $error("primary dead time not loaded");
    a_primHold: assert property (p_primHold) else $error("primary dead time moved unasked");
    a_altWr: assert property (p_altWr) else $error("alternate dead time not loaded");
    a_rdZero: assert property (p_rdZero) else $error("dead-time upper bits not zero");
    a_ready: assert property (p_ready) else $error("answer not one cycle after take");
    a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule : pgcd_asserts

bind pgcd_top pgcd_asserts chk (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .independentPeriodSelect(independentPeriodSelect),
    .centerAlignedActive(centerAlignedActive),
    .extPeriodResetActive(extPeriodResetActive),
    .risingDeadTime(risingDeadTime),
    .fallingDeadTime(fallingDeadTime)
);

// ===== verif/pgcd_tb.sv
`timescale 1ns/10ps
// ==========================================================
// register-level bench for the generator control block
module testbench;
    logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdData;
    logic faultEvent = 1'b0, currentLimitEvent = 1'b0, triggerEvent = 1'b0;
    logic pready, pslverr, ips, center_aligned_select, ext, mds, mps, dtp, iue, modEn, irq, rdErr;
    logic [1:0] dtc;
    logic [13:0] riseDt, fallDt;
    logic [15:0] cv [4] = '{16'h0004, 16'h0204, 16'h0002, 16'h0206};
    logic [2:0] cx [4] = '{3'b000, 3'b110, 3'b000, 3'b111};
    int n_mismatch = 0, num_checks = 0, cycCnt = 0;
    // 40 mhz clock
    always #12.5 core_clk = ~core_clk;
    pgcd_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .faultEvent(faultEvent), .currentLimitEvent(currentLimitEvent), .triggerEvent(triggerEvent),
        .independentPeriodSelect(ips), .centerAlignedActive(center_aligned_select), .extPeriodResetActive(ext),
        .masterDutySelect(mds), .masterPeriodSelect(mps), .deadTimeCtrl(dtc), .deadTimePolarity(dtp),
        .immediateUpdate(iue), .risingDeadTime(riseDt), .fallingDeadTime(fallDt), .moduleEnable(modEn), .irq(irq));
    // verdict and end of run
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rdData = prdata; rdErr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdData, exp, "read data");
    endtask : rd
    // one-cycle event pulses: bit0 fault, bit1 limit, bit2 trigger
    task pulse(input logic [2:0] ev);
        @(posedge core_clk);
        {triggerEvent, currentLimitEvent, faultEvent} <= ev;
        @(posedge core_clk);
        {triggerEvent, currentLimitEvent, faultEvent} <= 3'b000;
        @(posedge core_clk);
    endtask : pulse
    // hang guard
    always @(posedge core_clk) begin
        cycCnt++;
        if (cycCnt == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk(irq, 1'b0, "irq after reset");
        rd(pgcd_pkg::GEN_CTRL_ADDR, 32'h0);
        rd(pgcd_pkg::ALT_DT_ADDR, 32'h0);
        apb(1'b1, pgcd_pkg::PRIM_DT_ADDR, 32'hffff_ffff);
        rd(pgcd_pkg::PRIM_DT_ADDR, 32'h0000_3fff);
        chk(riseDt, 14'h3fff, "primary dead time");
        apb(1'b1, pgcd_pkg::ALT_DT_ADDR, 32'hc000_2a5a);
        rd(pgcd_pkg::ALT_DT_ADDR, 32'h0000_2a5a);
        chk(fallDt, 14'h2a5a, "alternate dead time");
        // mode table with limit mode clear
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, pgcd_pkg::GEN_CTRL_ADDR, {16'h0, cv[i]});
            chk({ips, center_aligned_select, ext}, cx[i], "mode outputs");
        end
        // remaining control fields pass straight through
        apb(1'b1, pgcd_pkg::GEN_CTRL_ADDR, 32'h0000_0141);
        chk({mds, mps, dtc, dtp, iue}, 6'h25, "control fields a");
        apb(1'b1, pgcd_pkg::GEN_CTRL_ADDR, 32'h0000_00a8);
        chk({mds, mps, dtc, dtp, iue}, 6'h1a, "control fields b");
        apb(1'b1, pgcd_pkg::FLT_CTRL_ADDR, 32'h1);
        apb(1'b1, pgcd_pkg::GEN_CTRL_ADDR, 32'h0216);
        chk({ips, center_aligned_select, ext}, 3'b110, "period reset blocked");
        rd(pgcd_pkg::GEN_CTRL_ADDR, 32'h0206);
        // pending flags and interrupt
        apb(1'b1, pgcd_pkg::IRQ_MASK_ADDR, 32'h7);
        apb(1'b1, pgcd_pkg::GEN_CTRL_ADDR, 32'h1c00);
        pulse(3'b111);
        chk(irq, 1'b1, "irq raised");
        rd(pgcd_pkg::GEN_CTRL_ADDR, 32'hfc00);
        apb(1'b1, pgcd_pkg::IRQ_STAT_ADDR, 32'h0);
        rd(pgcd_pkg::IRQ_STAT_ADDR, 32'h7);
        rd(pgcd_pkg::IRQ_STAT_ADDR, 32'h0);
        chk(irq, 1'b0, "irq cleared");
        apb(1'b1, pgcd_pkg::GEN_CTRL_ADDR, 32'h0800);
        rd(pgcd_pkg::GEN_CTRL_ADDR, 32'h4800);
        apb(1'b1, pgcd_pkg::IRQ_MASK_ADDR, 32'h0);
        apb(1'b1, pgcd_pkg::GEN_CTRL_ADDR, 32'h0);
        pulse(3'b001);
        chk(irq, 1'b0, "masked irq");
        rd(pgcd_pkg::GEN_CTRL_ADDR, 32'h8000);
        rd(pgcd_pkg::IRQ_STAT_ADDR, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        chk(rdErr, 1'b1, "unmapped error flag");
        chk(rdData, 32'h0, "unmapped read data");
        apb(1'b1, pgcd_pkg::GLOBAL_ADDR, 32'h1);
        chk(modEn, 1'b1, "global enable");
        // mid-run reset returns registered outputs to zero
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        chk(riseDt, 14'h0000, "primary dead time after reset");
        chk(fallDt, 14'h0000, "alternate dead time after reset");
        chk(modEn, 1'b0, "global enable after reset");
        end_sim();
    end
endmodule : testbench
